//--- hw/tks_sequencer.v
// touch-key acquisition sequencer with option straps and open-drain outputs
`timescale 1ns/1ps
`include "tks_defs.vh"

// Summary of operation
// - key0 option strap high enables neighbour-key lockout, low disables it.
// - four open-drain active-low touch outputs pull low while key touched.
// - about 20 ms after reset, one ~500 ns low pulse on output two.
// - key1 option strap high selects fast mode, low selects slow mode.
// - fast mode sleeps 16 ms between burst acquisitions.
// - slow mode sleeps 64 ms between burst acquisitions.
// - after each sleep-timer wake, wait 500 us before acquiring; a stuck-touch timeout in sleep starts calibration at once.
// - calibration takes several rapid acquisitions and sets each baseline.
// - initial calibration starts about 50 ms after power-up.
// - recalibrate on stuck-touch timeout or positive recalibration condition.
// - detect at 10 counts change, release below 8 counts.
// - per-key counter needs 5 consecutive acquisitions above threshold to touch.
// - with lockout, at most one of four keys reported touched.
// - a detection lasting over about 30 s forces recalibration.
module tks_sequencer #(
  parameter SIG_W = 16,
  parameter TOUCH_OUT_2_N_DELAY_CYC = `TKS_TOUCH_OUT_2_N_DELAY_CYC,
  parameter CAL_DELAY_CYC = `TKS_CAL_DELAY_CYC,
  parameter FAST_SLEEP_CYC = `TKS_FAST_SLEEP_CYC,
  parameter SLOW_SLEEP_CYC = `TKS_SLOW_SLEEP_CYC,
  parameter SETTLE_CYC = `TKS_SETTLE_CYC,
  parameter MAXON_CYC = `TKS_MAXON_CYC
) (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  // option straps
  input wire KEY0_OPTION_PIN,
  input wire KEY1_OPTION_PIN,
  // measurement front end
  output reg ACQ_REQ,
  input wire ACQ_DONE,
  input wire [SIG_W-1:0] SIG0,
  input wire [SIG_W-1:0] SIG1,
  input wire [SIG_W-1:0] SIG2,
  input wire [SIG_W-1:0] SIG3,
  // touch outputs, open drain
  output reg TOUCH_OUT_0_N_O,
  output reg TOUCH_OUT_0_N_OE,
  output reg TOUCH_OUT_1_N_O,
  output reg TOUCH_OUT_1_N_OE,
  output reg TOUCH_OUT_2_N_O,
  output reg TOUCH_OUT_2_N_OE,
  output reg TOUCH_OUT_3_N_O,
  output reg TOUCH_OUT_3_N_OE,
  // status
  output reg NEIGHBOUR_KEY_LOCKOUT,
  output reg FAST_MODE,
  output reg CAL_ACTIVE
);

  localparam [2:0] ST_BOOT = 3'h0;
  localparam [2:0] ST_CREQ = 3'h1;
  localparam [2:0] ST_CWAIT = 3'h2;
  localparam [2:0] ST_AREQ = 3'h3;
  localparam [2:0] ST_AWAIT = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;
  localparam [2:0] ST_SETTLE = 3'h6;

  localparam integer BOOT_END = CAL_DELAY_CYC - 1;
  localparam integer PULSE_BEG = TOUCH_OUT_2_N_DELAY_CYC;
  localparam integer PULSE_END = TOUCH_OUT_2_N_DELAY_CYC + `TKS_PULSE_CYC;
  localparam integer FAST_END = FAST_SLEEP_CYC - 1;
  localparam integer SLOW_END = SLOW_SLEEP_CYC - 1;
  localparam integer SETTLE_END = SETTLE_CYC - 1;
  localparam integer MAXON_END = MAXON_CYC - 1;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg [1:0] k0_sync_ff;
  reg [1:0] k1_sync_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`TKS_BOOT_W-1:0] boot_cnt_ff;
  reg [`TKS_SLEEP_W-1:0] sleep_cnt_ff;
  reg [`TKS_SETTLE_W-1:0] settle_cnt_ff;
  reg [`TKS_MAXON_W-1:0] maxon_cnt_ff;
  reg [1:0] cal_idx_ff;
  reg [SIG_W+1:0] acc_ff [0:3];
  reg [SIG_W+1:0] cal_sum [0:3];
  reg [SIG_W-1:0] ref_ff [0:3];
  reg [2:0] cnt_ff [0:3];
  reg [2:0] nxt_cnt [0:3];
  reg [3:0] touch_ff;
  reg [3:0] nxt_touch;
  reg [3:0] cand;
  reg [3:0] nxt_oe;
  reg signed [SIG_W:0] dl [0:3];
  reg pos_recal;
  reg granted;
  wire [SIG_W-1:0] sig [0:3];
  wire maxon_exp;
  wire sleep_done;
  wire touch_out_2_n_pulse;
  integer k;

  assign sig[0] = SIG0;
  assign sig[1] = SIG1;
  assign sig[2] = SIG2;
  assign sig[3] = SIG3;

  ////////////////////////////////////////////////////////////////////////////
  // strap synchronisers

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      k0_sync_ff <= 2'h0;
      k1_sync_ff <= 2'h0;
    end
    else
    begin
      k0_sync_ff <= {k0_sync_ff[0], KEY0_OPTION_PIN};
      k1_sync_ff <= {k1_sync_ff[0], KEY1_OPTION_PIN};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers

  assign touch_out_2_n_pulse = (boot_cnt_ff >= PULSE_BEG) && (boot_cnt_ff < PULSE_END);
  assign sleep_done = FAST_MODE ? (sleep_cnt_ff >= FAST_END) : (sleep_cnt_ff >= SLOW_END);
  assign maxon_exp = (maxon_cnt_ff >= MAXON_END);

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      boot_cnt_ff <= {`TKS_BOOT_W{1'b0}};
      sleep_cnt_ff <= {`TKS_SLEEP_W{1'b0}};
      settle_cnt_ff <= {`TKS_SETTLE_W{1'b0}};
      maxon_cnt_ff <= {`TKS_MAXON_W{1'b0}};
    end
    else
    begin
      if ((boot_cnt_ff < BOOT_END) || (boot_cnt_ff < PULSE_END))
        boot_cnt_ff <= boot_cnt_ff + 1'b1;
      if (state_ff == ST_SLEEP)
        sleep_cnt_ff <= sleep_cnt_ff + 1'b1;
      else
        sleep_cnt_ff <= {`TKS_SLEEP_W{1'b0}};
      if (state_ff == ST_SETTLE)
        settle_cnt_ff <= settle_cnt_ff + 1'b1;
      else
        settle_cnt_ff <= {`TKS_SETTLE_W{1'b0}};
      if ((|touch_ff) && !maxon_exp)
        maxon_cnt_ff <= maxon_cnt_ff + 1'b1;
      else if (!(|touch_ff))
        maxon_cnt_ff <= {`TKS_MAXON_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key evaluation

  always @*
  begin
    pos_recal = 1'b0;
    granted = 1'b0;
    cand = 4'h0;
    nxt_touch = touch_ff;
    for (k = 0; k < 4; k = k + 1)
    begin
      dl[k] = $signed({1'b0, ref_ff[k]}) - $signed({1'b0, sig[k]});
      cal_sum[k] = acc_ff[k] + {2'h0, sig[k]};
      nxt_cnt[k] = cnt_ff[k];
      if (touch_ff[k])
      begin
        if (dl[k] < $signed(`TKS_THRESH_OFF))
        begin
          nxt_touch[k] = 1'b0;
          nxt_cnt[k] = 3'h0;
        end
      end
      else if (dl[k] >= $signed(`TKS_THRESH_ON))
      begin
        if (cnt_ff[k] >= 3'd`TKS_DI_LIMIT - 3'd1)
        begin
          cand[k] = 1'b1;
          nxt_cnt[k] = 3'd`TKS_DI_LIMIT;
        end
        else
          nxt_cnt[k] = cnt_ff[k] + 3'd1;
      end
      else
        nxt_cnt[k] = 3'h0;
      if (dl[k] <= -$signed(`TKS_POS_RECAL))
        pos_recal = 1'b1;
    end
    for (k = 0; k < 4; k = k + 1)
    begin
      if (cand[k])
      begin
        // with lockout, single group, one key at a time; without it every candidate key is set
        if (NEIGHBOUR_KEY_LOCKOUT)
        begin
          if (!granted && !(|nxt_touch))
          begin
            nxt_touch[k] = 1'b1;
            granted = 1'b1;
          end
        end
        else
          nxt_touch[k] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_BOOT:
        if (boot_cnt_ff >= BOOT_END)
          nxt_state = ST_CREQ;
      ST_CREQ:
        nxt_state = ST_CWAIT;
      ST_CWAIT:
        if (ACQ_DONE)
          nxt_state = (cal_idx_ff == `TKS_CAL_SAMPLES - 1) ? ST_AREQ : ST_CREQ;
      ST_AREQ:
        nxt_state = ST_AWAIT;
      ST_AWAIT:
        if (ACQ_DONE)
          nxt_state = (pos_recal || maxon_exp) ? ST_CREQ : ST_SLEEP;
      ST_SLEEP:
        if (maxon_exp)
          nxt_state = ST_CREQ;
        else if (sleep_done)
          nxt_state = ST_SETTLE;
      ST_SETTLE:
        if (settle_cnt_ff >= SETTLE_END)
          nxt_state = ST_AREQ;
      default:
        nxt_state = ST_BOOT;
    endcase
  end

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_ff <= ST_BOOT;
      cal_idx_ff <= 2'h0;
      touch_ff <= 4'h0;
      NEIGHBOUR_KEY_LOCKOUT <= 1'b0;
      FAST_MODE <= 1'b0;
      for (k = 0; k < 4; k = k + 1)
      begin
        acc_ff[k] <= {(SIG_W+2){1'b0}};
        ref_ff[k] <= {SIG_W{1'b0}};
        cnt_ff[k] <= 3'h0;
      end
    end
    else
    begin
      state_ff <= nxt_state;
      if ((state_ff == ST_BOOT) && (nxt_state == ST_CREQ))
      begin
        NEIGHBOUR_KEY_LOCKOUT <= k0_sync_ff[1];
        FAST_MODE <= k1_sync_ff[1];
      end
      if (state_ff == ST_CREQ)
      begin
        touch_ff <= 4'h0;
        for (k = 0; k < 4; k = k + 1)
          cnt_ff[k] <= 3'h0;
      end
      if ((state_ff == ST_CWAIT) && ACQ_DONE)
      begin
        cal_idx_ff <= cal_idx_ff + 2'd1;
        for (k = 0; k < 4; k = k + 1)
        begin
          if (cal_idx_ff == 2'h0)
            acc_ff[k] <= {2'h0, sig[k]};
          else
            acc_ff[k] <= cal_sum[k];
          if (cal_idx_ff == `TKS_CAL_SAMPLES - 1)
            ref_ff[k] <= cal_sum[k][SIG_W+1:`TKS_CAL_SHIFT];
        end
      end
      if ((state_ff == ST_AWAIT) && ACQ_DONE)
      begin
        touch_ff <= nxt_touch;
        for (k = 0; k < 4; k = k + 1)
          cnt_ff[k] <= nxt_cnt[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always @*
  begin
    // released during calibration
    // pins drop in the same edge as the calibration flag rises
    nxt_oe = ((nxt_state == ST_CREQ) || (nxt_state == ST_CWAIT)) ? 4'h0 : touch_ff;
    if (touch_out_2_n_pulse)
      nxt_oe[2] = 1'b1;
  end

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ACQ_REQ <= 1'b0;
      CAL_ACTIVE <= 1'b0;
      TOUCH_OUT_0_N_O <= 1'b0;
      TOUCH_OUT_1_N_O <= 1'b0;
      TOUCH_OUT_2_N_O <= 1'b0;
      TOUCH_OUT_3_N_O <= 1'b0;
      TOUCH_OUT_0_N_OE <= 1'b0;
      TOUCH_OUT_1_N_OE <= 1'b0;
      TOUCH_OUT_2_N_OE <= 1'b0;
      TOUCH_OUT_3_N_OE <= 1'b0;
    end
    else
    begin
      ACQ_REQ <= (nxt_state == ST_CREQ) || (nxt_state == ST_AREQ);
      CAL_ACTIVE <= (nxt_state == ST_CREQ) || (nxt_state == ST_CWAIT);
      TOUCH_OUT_0_N_OE <= nxt_oe[0];
      TOUCH_OUT_1_N_OE <= nxt_oe[1];
      TOUCH_OUT_2_N_OE <= nxt_oe[2];
      TOUCH_OUT_3_N_OE <= nxt_oe[3];
    end
  end

endmodule // tks_sequencer

//--- hw/tks_defs.vh
// constants for the touch-key sequencer
`ifndef TKS_DEFS_VH
`define TKS_DEFS_VH

// clock rate
`define TKS_CLK_KHZ 25000

// times as printed
`define TKS_PULSE_NS 500
`define TKS_TOUCH_OUT_2_N_DELAY_MS 20
`define TKS_CAL_DELAY_MS 50
`define TKS_FAST_SLEEP_MS 16
`define TKS_SLOW_SLEEP_MS 64
`define TKS_SETTLE_US 500
`define TKS_MAXON_S 30

// times as clock cycles
`define TKS_PULSE_CYC ((`TKS_PULSE_NS * `TKS_CLK_KHZ + 999999) / 1000000)
`define TKS_TOUCH_OUT_2_N_DELAY_CYC (`TKS_TOUCH_OUT_2_N_DELAY_MS * `TKS_CLK_KHZ)
`define TKS_CAL_DELAY_CYC (`TKS_CAL_DELAY_MS * `TKS_CLK_KHZ)
`define TKS_FAST_SLEEP_CYC (`TKS_FAST_SLEEP_MS * `TKS_CLK_KHZ)
`define TKS_SLOW_SLEEP_CYC (`TKS_SLOW_SLEEP_MS * `TKS_CLK_KHZ)
`define TKS_SETTLE_CYC ((`TKS_SETTLE_US * `TKS_CLK_KHZ) / 1000)
`define TKS_MAXON_CYC (`TKS_MAXON_S * `TKS_CLK_KHZ * 1000)

// detection figures
`define TKS_THRESH_ON 10
`define TKS_THRESH_OFF 8
`define TKS_DI_LIMIT 5
`define TKS_POS_RECAL 10
`define TKS_CAL_SAMPLES 4
`define TKS_CAL_SHIFT 2

// counter widths
`define TKS_BOOT_W 21
`define TKS_SLEEP_W 21
`define TKS_SETTLE_W 14
`define TKS_MAXON_W 30
`define TKS_PULSE_W 4

`endif

//--- tb/tks_front_model.sv
// front-end model answering burst requests
`timescale 1ns/1ps
module tks_front_model (
  // clock and reset
  input wire clk,
  input wire rstn,
  // request and answer
  input wire acq_req,
  input wire [1:0] lat,
  input wire [63:0] val,
  output reg acq_done,
  output reg [63:0] sig
);
  reg pend_ff;
  reg [1:0] wait_ff;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_ff <= 1'b0;
      wait_ff <= 2'h0;
      acq_done <= 1'b0;
      sig <= 64'h0;
    end
    else
    begin
      acq_done <= 1'b0;
      sig <= ~sig;
      if (acq_req)
      begin
        pend_ff <= 1'b1;
        wait_ff <= lat;
      end
      else if (pend_ff && wait_ff == 2'h0)
      begin
        pend_ff <= 1'b0;
        acq_done <= 1'b1;
        sig <= val;
      end
      else if (pend_ff)
        wait_ff <= wait_ff - 2'h1;
    end
  end
endmodule // tks_front_model

//--- tb/tks_sequencer_asserts.sv
// assertion checker for the touch-key sequencer
`timescale 1ns/1ps
module tks_sequencer_asserts #(
  parameter CAL_DELAY_CYC = 100,
  parameter FAST_SLEEP_CYC = 20,
  parameter SLOW_SLEEP_CYC = 40,
  parameter SETTLE_CYC = 10
) (
  // clock, reset, straps
  input wire CLK,
  input wire RSTN,
  input wire KEY0_OPTION_PIN,
  input wire KEY1_OPTION_PIN,
  // front end
  input wire ACQ_REQ,
  input wire ACQ_DONE,
  // pins and status
  input wire TOUCH_OUT_0_N_O,
  input wire TOUCH_OUT_0_N_OE,
  input wire TOUCH_OUT_1_N_O,
  input wire TOUCH_OUT_1_N_OE,
  input wire TOUCH_OUT_2_N_O,
  input wire TOUCH_OUT_2_N_OE,
  input wire TOUCH_OUT_3_N_O,
  input wire TOUCH_OUT_3_N_OE,
  input wire NEIGHBOUR_KEY_LOCKOUT,
  input wire FAST_MODE,
  input wire CAL_ACTIVE
);
  wire [3:0] oe;
  reg seen_ff;
  reg arm_ff;
  reg [31:0] plen_ff;
  reg [31:0] boot_ff;
  reg [31:0] gap_ff;
  assign oe = {TOUCH_OUT_3_N_OE, TOUCH_OUT_2_N_OE, TOUCH_OUT_1_N_OE, TOUCH_OUT_0_N_OE};
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      seen_ff <= 1'b0;
      arm_ff <= 1'b0;
      plen_ff <= 32'h0;
      boot_ff <= 32'h0;
      gap_ff <= 32'h0;
    end
    else
    begin
      seen_ff <= seen_ff | ACQ_REQ;
      arm_ff <= (ACQ_DONE & ~CAL_ACTIVE) | (arm_ff & ~ACQ_REQ);
      plen_ff <= TOUCH_OUT_2_N_OE ? plen_ff + 32'h1 : 32'h0;
      boot_ff <= seen_ff ? boot_ff : boot_ff + 32'h1;
      gap_ff <= (ACQ_DONE & ~CAL_ACTIVE) ? 32'h0 : gap_ff + 32'h1;
    end
  end
  //////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_od_low: assert property ({TOUCH_OUT_3_N_O, TOUCH_OUT_2_N_O, TOUCH_OUT_1_N_O, TOUCH_OUT_0_N_O} == 4'h0)
    else $error("touch pin data not low");
  a_cal_quiet: assert property (CAL_ACTIVE |-> oe == 4'h0)
    else $error("pin pulled during calibration");
  a_lock_one: assert property (NEIGHBOUR_KEY_LOCKOUT |-> $onehot0(oe))
    else $error("two keys with lockout");
  a_pulse_len: assert property ($fell(TOUCH_OUT_2_N_OE) && !seen_ff |-> plen_ff == 32'd13)
    else $error("start pulse width");
  a_cal_start: assert property (ACQ_REQ && !seen_ff |-> boot_ff + 2 >= CAL_DELAY_CYC && boot_ff <= CAL_DELAY_CYC + 2)
    else $error("first calibration time");
  a_cal_rapid: assert property (ACQ_DONE && CAL_ACTIVE |-> ##[1:2] ACQ_REQ)
    else $error("calibration not back to back");
  a_fast_gap: assert property ((ACQ_REQ && arm_ff && FAST_MODE ##1 !CAL_ACTIVE) |->
    $past(gap_ff) + 1 >= FAST_SLEEP_CYC + SETTLE_CYC && $past(gap_ff) <= FAST_SLEEP_CYC + SETTLE_CYC + 3)
    else $error("fast sleep gap");
  a_slow_gap: assert property ((ACQ_REQ && arm_ff && !FAST_MODE ##1 !CAL_ACTIVE) |->
    $past(gap_ff) + 1 >= SLOW_SLEEP_CYC + SETTLE_CYC && $past(gap_ff) <= SLOW_SLEEP_CYC + SETTLE_CYC + 3)
    else $error("slow sleep gap");
  a_strap_map: assert property (seen_ff |-> NEIGHBOUR_KEY_LOCKOUT == KEY0_OPTION_PIN && FAST_MODE == KEY1_OPTION_PIN)
    else $error("strap flags wrong");
  a_strap_held: assert property (seen_ff |-> $stable(NEIGHBOUR_KEY_LOCKOUT) && $stable(FAST_MODE))
    else $error("strap flags moved");
  c_fast: cover property (ACQ_REQ && arm_ff && FAST_MODE);
  c_slow: cover property (ACQ_REQ && arm_ff && !FAST_MODE);
  c_lock: cover property (NEIGHBOUR_KEY_LOCKOUT && oe != 4'h0);
endmodule // tks_sequencer_asserts

bind tks_sequencer tks_sequencer_asserts #(.CAL_DELAY_CYC(CAL_DELAY_CYC), .FAST_SLEEP_CYC(FAST_SLEEP_CYC),
  .SLOW_SLEEP_CYC(SLOW_SLEEP_CYC), .SETTLE_CYC(SETTLE_CYC)) chk_i (.CLK(CLK), .RSTN(RSTN),
  .KEY0_OPTION_PIN(KEY0_OPTION_PIN), .KEY1_OPTION_PIN(KEY1_OPTION_PIN), .ACQ_REQ(ACQ_REQ), .ACQ_DONE(ACQ_DONE),
  .TOUCH_OUT_0_N_O(TOUCH_OUT_0_N_O), .TOUCH_OUT_0_N_OE(TOUCH_OUT_0_N_OE), .TOUCH_OUT_1_N_O(TOUCH_OUT_1_N_O),
  .TOUCH_OUT_1_N_OE(TOUCH_OUT_1_N_OE), .TOUCH_OUT_2_N_O(TOUCH_OUT_2_N_O), .TOUCH_OUT_2_N_OE(TOUCH_OUT_2_N_OE),
  .TOUCH_OUT_3_N_O(TOUCH_OUT_3_N_O), .TOUCH_OUT_3_N_OE(TOUCH_OUT_3_N_OE),
  .NEIGHBOUR_KEY_LOCKOUT(NEIGHBOUR_KEY_LOCKOUT), .FAST_MODE(FAST_MODE), .CAL_ACTIVE(CAL_ACTIVE));

//--- tb/touch_key_sequencer_test.sv
// self-checking bench for the touch-key sequencer
`timescale 1ns/1ps
module touch_key_sequencer_test;
  reg clk, rstn, key0, key1, is_cal, stuck_ok, hit, pos;
  reg [1:0] lat;
  reg [63:0] val;
  reg [31:0] rnd;
  reg [3:0] tch;
  wire acq_req, acq_done, lock, fast, cal;
  wire [63:0] sig;
  wire [3:0] o, oe, pin_n;
  integer err_count, n_checks, i, k, n, cal_left;
  integer rf[0:3], cnt[0:3], sum[0:3], d[0:3];
  // shortened timings for simulation
  localparam integer T_TOUCH_OUT_2_N = 50, T_CAL = 100, T_FAST = 20, T_SLOW = 40, T_SETTLE = 10, T_MAXON = 300;
  // open-drain pins with pull-up
  assign pin_n = (o & oe) | ~oe;
  tks_sequencer #(.TOUCH_OUT_2_N_DELAY_CYC(T_TOUCH_OUT_2_N), .CAL_DELAY_CYC(T_CAL), .FAST_SLEEP_CYC(T_FAST),
    .SLOW_SLEEP_CYC(T_SLOW), .SETTLE_CYC(T_SETTLE), .MAXON_CYC(T_MAXON)) dut (.CLK(clk), .RSTN(rstn),
    .KEY0_OPTION_PIN(key0),
    .KEY1_OPTION_PIN(key1), .ACQ_REQ(acq_req), .ACQ_DONE(acq_done), .SIG0(sig[15:0]), .SIG1(sig[31:16]),
    .SIG2(sig[47:32]), .SIG3(sig[63:48]), .TOUCH_OUT_0_N_O(o[0]), .TOUCH_OUT_0_N_OE(oe[0]),
    .TOUCH_OUT_1_N_O(o[1]), .TOUCH_OUT_1_N_OE(oe[1]), .TOUCH_OUT_2_N_O(o[2]), .TOUCH_OUT_2_N_OE(oe[2]),
    .TOUCH_OUT_3_N_O(o[3]), .TOUCH_OUT_3_N_OE(oe[3]), .NEIGHBOUR_KEY_LOCKOUT(lock), .FAST_MODE(fast),
    .CAL_ACTIVE(cal));
  tks_front_model fm (.clk(clk), .rstn(rstn), .acq_req(acq_req), .lat(lat), .val(val),
    .acq_done(acq_done), .sig(sig));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  //////////////////////////////
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task give_verdict;
    begin
      if (err_count == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [3:0] ex, input [3:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== ex)
      begin
        err_count = err_count + 1;
        $display("FAIL %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task hang;
    begin
      err_count = err_count + 1;
      $display("FAIL wait exp 1 got 0");
      give_verdict;
    end
  endtask
  task do_reset(input l, input f);
    begin
      @(posedge clk);
      rstn <= 1'b0;
      key0 <= l;
      key1 <= f;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      cal_left = 4;
      n = 0;
      repeat (90)
      begin
        @(posedge clk);
        if (oe[2] === 1'b1) n = n + 1;
      end
      chk("pulse", 4'hd, n[3:0]);
    end
  endtask
  task acq(input integer a, input integer b, input integer c, input integer e);
    begin
      d[0] = a;
      d[1] = b;
      d[2] = c;
      d[3] = e;
      rnd = lfsr(rnd);
      lat <= rnd[1:0];
      i = 0;
      do
      begin
        @(posedge clk);
        i = i + 1;
      end while (acq_req !== 1'b1 && i < 3000);
      if (i >= 3000) hang;
      #1;
      if (cal === 1'b1 && cal_left == 0 && stuck_ok)
      begin
        hit = 1'b1;
        cal_left = 4;
      end
      chk("cal", {3'h0, cal_left > 0}, {3'h0, cal});
      is_cal = cal_left > 0;
      if (!is_cal) chk("touch", tch, ~pin_n);
      if (cal_left == 4)
      begin
        tch = 4'h0;
        for (k = 0; k < 4; k = k + 1)
        begin
          sum[k] = 0;
          cnt[k] = 0;
        end
      end
      for (k = 0; k < 4; k = k + 1)
        val[16*k +: 16] = is_cal ? 16'd600 + rnd[2*k +: 2] : rf[k] - d[k];
      i = 0;
      do
      begin
        @(posedge clk);
        i = i + 1;
      end while (acq_done !== 1'b1 && i < 10);
      if (i >= 10) hang;
      pos = 1'b0;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (is_cal) sum[k] = sum[k] + val[16*k +: 16];
        else if (d[k] <= -10) pos = 1'b1;
        if (!is_cal && tch[k] && d[k] < 8)
        begin
          tch[k] = 1'b0;
          cnt[k] = 0;
        end
        else if (!is_cal && !tch[k]) cnt[k] = d[k] >= 10 ? cnt[k] + 1 : 0;
      end
      for (k = 0; k < 4; k = k + 1)
        if (!is_cal && !tch[k] && cnt[k] >= 5 && (!key0 || tch == 4'h0)) tch[k] = 1'b1;
      if (pos) cal_left = 4;
      if (is_cal) cal_left = cal_left - 1;
      if (is_cal && cal_left == 0)
        for (k = 0; k < 4; k = k + 1)
          rf[k] = sum[k] >> 2;
    end
  endtask
  //////////////////////////////
  initial
  begin
    rstn = 1'b0;
    key0 = 1'b1;
    key1 = 1'b1;
    lat = 2'h0;
    val = 64'h0;
    rnd = 32'ha31e;
    err_count = 0;
    n_checks = 0;
    stuck_ok = 1'b0;
    hit = 1'b0;
    tch = 4'h0;
    do_reset(1'b1, 1'b1);
    repeat (4) acq(0, 0, 0, 0);
    chk("mode", {2'h0, key0, key1}, {2'h0, lock, fast});
    repeat (5) acq(0, 10, 10, 0);
    acq(0, 9, 10, 0);
    acq(0, 7, 0, 0);
    repeat (4) acq(0, 0, 10, 0);
    acq(0, 0, 9, 0);
    repeat (5) acq(0, 0, 10, 0);
    acq(-10, 0, 0, 0);
    repeat (5) acq(0, 0, 0, 0);
    do_reset(1'b0, 1'b0);
    repeat (4) acq(0, 0, 0, 0);
    chk("mode", {2'h0, key0, key1}, {2'h0, lock, fast});
    stuck_ok = 1'b1;
    n = 0;
    while (!hit && n < 20)
    begin
      acq(12, 0, 0, 10);
      n = n + 1;
    end
    chk("stuck", 4'h1, {3'h0, n >= 10 && n <= 12});
    repeat (5) acq(0, 0, 0, 0);
    give_verdict;
  end
endmodule // touch_key_sequencer_test
